// ===== src/vpi_unit.sv
// Vectored interrupt unit: request latching, masking and fixed priority grant.
// Assumes all inputs synchronous to clk_i; CPU pulses instr_done_i per instruction.
`timescale 1ns/1ps
module vpi_unit #(
	parameter int NSRC = vpi_pkg::NSRC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [14:0] src_lvl_i,
	input wire logic [14:0] en_i,
	input wire logic pin_lvl_i,
	input wire logic pin_rise_sel_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic bus_rise_sel_i,
	input wire logic gdis_set_i,
	input wire logic gdis_clr_i,
	input wire logic req_wr_i,
	input wire logic [14:0] req_wdata_i,
	input wire logic instr_done_i,
	input wire logic ack_i,
	output logic irq_o,
	output logic [3:0] src_o,
	output logic [15:0] vec_lo_o,
	output logic [15:0] vec_hi_o,
	output logic [14:0] req_o,
	output logic gdis_o
);
	initial begin
		if (NSRC != 15) $error("vpi_unit serves exactly 15 sources");
	end

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0] rs;
		logic [14:0] req;
		logic [14:0] pend_wr;
		logic wr_wait;
		logic gdis;
		logic pin_d;
		logic scl_d;
		logic sda_d;
		logic [14:0] src_d;
		logic irq;
		logic [3:0] src;
		logic [15:0] vlo;
		logic [15:0] vhi;
	} vpi_state_t;

	vpi_state_t st_r;
	vpi_state_t st_nxt;
	logic rst_n;
	assign rst_n = st_r.rs[1];

	////////////////////////////////////////////////////////////////////////
	logic [14:0] edge_ev;
	logic [14:0] elig;
	logic pin_rise, pin_fall, scl_e, sda_e;
	logic [3:0] win;
	logic found;

	always_comb begin
		pin_rise = pin_lvl_i & ~st_r.pin_d;
		pin_fall = ~pin_lvl_i & st_r.pin_d;
		scl_e = bus_rise_sel_i ? (scl_i & ~st_r.scl_d) : (~scl_i & st_r.scl_d);
		sda_e = bus_rise_sel_i ? (sda_i & ~st_r.sda_d) : (~sda_i & st_r.sda_d);
		edge_ev = src_lvl_i & ~st_r.src_d;
		edge_ev[0] = 1'b0;
		edge_ev[vpi_pkg::SRC_PIN] = pin_rise_sel_i ? pin_rise : pin_fall;
		edge_ev[vpi_pkg::SRC_BUS] = scl_e | sda_e;
		elig = st_r.req & en_i & {15{~st_r.gdis}};
		win = 4'h0;
		found = 1'b0;
		for (int i = NSRC - 1; i >= 1; i--) begin
			if (elig[i]) begin
				win = 4'(i);
				found = 1'b1;
			end
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rs = {st_r.rs[0], 1'b1};
		st_nxt.pin_d = pin_lvl_i;
		st_nxt.scl_d = scl_i;
		st_nxt.sda_d = sda_i;
		st_nxt.src_d = src_lvl_i;
		if (gdis_clr_i) st_nxt.gdis = 1'b0;
		if (gdis_set_i) st_nxt.gdis = 1'b1;
		// Software write lands one instruction later
		if (st_r.wr_wait && instr_done_i) begin
			st_nxt.req = st_r.pend_wr;
			st_nxt.wr_wait = 1'b0;
		end
		if (req_wr_i) begin
			st_nxt.pend_wr = req_wdata_i;
			st_nxt.wr_wait = 1'b1;
		end
		// Acknowledge clears granted bit and sets the global disable flag gdis
		if (ack_i && st_r.irq) begin
			st_nxt.req[st_r.src] = 1'b0;
			st_nxt.gdis = 1'b1;
		end
		// Set beats clear
		st_nxt.req = st_nxt.req | edge_ev;
		st_nxt.irq = found & ~(ack_i & st_r.irq);
		st_nxt.src = win;
		st_nxt.vlo = vpi_pkg::VEC_TOP_LO - 16'(win) * vpi_pkg::VEC_STEP;
		st_nxt.vhi = st_nxt.vlo + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
			st_r.gdis <= vpi_pkg::GDIS_RST;
			st_r.vlo <= vpi_pkg::VEC_TOP_LO;
			st_r.vhi <= vpi_pkg::VEC_TOP_LO + 16'h0001;
		end else if (!rst_n) begin
			st_r <= '0;
			st_r.rs <= {st_r.rs[0], 1'b1};
			st_r.gdis <= vpi_pkg::GDIS_RST;
			st_r.vlo <= vpi_pkg::VEC_TOP_LO;
			st_r.vhi <= vpi_pkg::VEC_TOP_LO + 16'h0001;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign irq_o = st_r.irq;
	assign src_o = st_r.src;
	assign vec_lo_o = st_r.vlo;
	assign vec_hi_o = st_r.vhi;
	assign req_o = st_r.req;
	assign gdis_o = st_r.gdis;
endmodule

// ===== src/vpi_pkg.sv
// Constants for the vectored priority interrupt unit.
// Assumes a CPU core that holds the global disable flag copy and fetches vectors.
// Function
// - Fifteen request sources, each serviced through its own vector address.
// - Simultaneous pending requests: highest fixed priority granted, others stay pending.
// - Per-source enable bits and a global disable flag gate all maskable sources.
// - Reset is non-maskable; vector high byte FFFD, low byte FFFC.
// - First external pin interrupt on selectable edge; vector FFFB / FFFA.
// - SCL or SDA edge raises interrupt on selectable edge; vector FFF9 / FFF8.
// - Written request bits take effect only after one more instruction.
// - Global disable flag is 1 after reset.
package vpi_pkg;
	localparam int NSRC = 15;
	// Source 0 is reset; vector low byte address = TOP - 2*index
	localparam logic [15:0] VEC_TOP_LO = 16'hfffc;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	localparam int SRC_PIN = 1;
	localparam int SRC_BUS = 2;
	localparam logic GDIS_RST = 1'h1;
	localparam logic [14:0] REQ_RST = 15'h0000;
	localparam logic [14:0] EN_RST = 15'h0000;
endpackage

// ===== tb/vpi_unit_properties.sv
// Port assertions for the interrupt unit.
// Assumes every input is synchronous to clk_i.
`timescale 1ns/1ps
module vpi_unit_properties (
	input wire logic clk_i, rst_n_i, ack_i, req_wr_i, irq_o, gdis_o,
	input wire logic [14:0] en_i, req_o,
	input wire logic [3:0] src_o,
	input wire logic [15:0] vec_lo_o, vec_hi_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_take; ack_i && irq_o; endsequence
	a_vec_pair: assert property (irq_o |-> vec_hi_o == vec_lo_o + 16'h0001) else $error("pair");
	a_vec_map: assert property (irq_o |-> vec_lo_o == 16'hfffc - {src_o, 1'b0}) else $error("map");
	a_rst_val: assert property ($rose(rst_n_i) |-> gdis_o && vec_lo_o == 16'hfffc) else $error("rst");
	a_prio_win: assert property (irq_o |-> ($past(req_o & en_i) & ((15'h0002 << src_o) - 15'h0001))
		== (15'h0001 << src_o)) else $error("prio");
	a_gdis_mask: assert property ($past(gdis_o) |-> !irq_o) else $error("mask");
	a_ack_gdis: assert property (s_take |=> gdis_o && !irq_o) else $error("ack");
	a_ack_clr: assert property (s_take |=> ((req_o >> $past(src_o)) & 15'h0001) == 15'h0000)
		else $error("clr");
	a_wr_late: assert property (req_wr_i |=> req_o == $past(req_o)) else $error("write");
endmodule
bind vpi_unit vpi_unit_properties u_props(.clk_i, .rst_n_i, .ack_i, .req_wr_i, .irq_o, .gdis_o,
	.en_i, .req_o, .src_o, .vec_lo_o, .vec_hi_o);

// ===== tb/vpi_cpu_model.sv
// CPU side: takes a raised interrupt, pulses instruction completion.
// Holding go_i low stalls the acceptance.
`timescale 1ns/1ps
module vpi_cpu_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic irq_i,
	output logic ack_o = 1'b0,
	output logic done_o = 1'b0
);
	always @(posedge clk_i) begin
		ack_o <= go_i && irq_i && !ack_o;
		done_o <= !done_o;
	end
endmodule

// ===== tb/vpi_unit_bench.sv
// Self-checking bench for the interrupt unit.
// Assumes the CPU model shares the unit's clock.
`timescale 1ns/1ps
module vpi_unit_bench;
	logic clk = 0, rst_n = 0, pin = 0, psel = 1, scl = 0, bsel = 1, gclr = 0, wr = 0, go = 1;
	logic sda = 0;
	logic [15:0] vh;
	logic irq, gd, ack, done;
	logic [14:0] lvl = 0, en = 0, req;
	logic [3:0] src;
	logic [15:0] vl;
	int err_count = 0, check_count = 0, cyc = 0;
	always #12.5 clk = ~clk;
	vpi_unit u_dut(.clk_i(clk), .rst_n_i(rst_n), .src_lvl_i(lvl), .en_i(en), .pin_lvl_i(pin),
		.pin_rise_sel_i(psel), .scl_i(scl), .sda_i(sda), .bus_rise_sel_i(bsel), .gdis_set_i(1'b0),
		.gdis_clr_i(gclr), .req_wr_i(wr), .req_wdata_i(15'h0040), .instr_done_i(done), .ack_i(ack),
		.irq_o(irq), .src_o(src), .vec_lo_o(vl), .vec_hi_o(vh), .req_o(req), .gdis_o(gd));
	vpi_cpu_model u_cpu(.clk_i(clk), .go_i(go), .irq_i(irq), .ack_o(ack), .done_o(done));
	task chk(input logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task fire(input logic [3:0] s);
		int n;
		for (n = 0; irq !== 1'b1 && n < 20; n++) @(negedge clk);
		chk(src, s);
		chk(vl, 16'hfffc - {s, 1'b0});
		chk(vh, 16'hfffd - {s, 1'b0});
		// Clear only after the ack has set the disable flag, else the set would win
		for (n = 0; irq !== 1'b0 && n < 20; n++) @(negedge clk);
		chk(gd, 1'b1);
		@(posedge clk) gclr <= 1;
		@(posedge clk) gclr <= 0;
		$display("source %0d served", s);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(negedge clk);
		chk(vl, 16'hfffc);
		chk(gd, 1'b1);
		@(posedge clk) {en, gclr, go, pin} <= {15'h7fff, 3'b101};
		@(posedge clk) gclr <= 0;
		repeat (6) @(negedge clk);
		chk(irq, 1'b1);
		@(posedge clk) go <= 1;
		fire(1);
		@(posedge clk) psel <= 0;
		@(posedge clk) pin <= 0;
		fire(1);
		@(posedge clk) scl <= 1;
		fire(2);
		@(posedge clk) bsel <= 0;
		@(posedge clk) scl <= 0;
		fire(2);
		@(posedge clk) sda <= 1;
		@(posedge clk) sda <= 0;
		fire(2);
		@(posedge clk) lvl <= 15'h7ff8;
		for (int i = 3; i < 15; i++) fire(i);
		@(posedge clk) {lvl, en} <= 30'h0;
		@(posedge clk) lvl <= 15'h0010;
		repeat (5) @(negedge clk);
		chk(irq, 1'b0);
		chk(req, 16'h0010);
		@(posedge clk) en <= 15'h7fff;
		fire(4);
		@(posedge clk) wr <= 1;
		@(posedge clk) wr <= 0;
		fire(6);
		close_out;
	end
endmodule
